// ===== rtl/ssf_pkg.sv
// Shared constants and types for the serial status flag block.
package ssf_pkg;

	// ==========================================================
	// Register map (byte addresses on the APB)
	// ==========================================================
	localparam logic [11:0] SSF_OFS_STATUS  = 12'h000; // Status flags.
	localparam logic [11:0] SSF_OFS_CONTROL = 12'h004; // Enables and frame format.
	localparam logic [11:0] SSF_OFS_RXDATA  = 12'h008; // Received character, read only.
	localparam logic [11:0] SSF_OFS_TXDATA  = 12'h00c; // Character to send.

	// ==========================================================
	// Status register field positions and register reset values
	// ==========================================================
	localparam int SSF_ST_TX_EMPTY    = 7; // Transmit data register empty.
	localparam int SSF_ST_RX_FULL     = 6; // Receive data register full.
	localparam int SSF_ST_OVERRUN     = 5; // Receive overrun.
	localparam int SSF_ST_FRAMING     = 4; // Framing error.
	localparam int SSF_ST_PARITY      = 3; // Parity error.
	localparam int SSF_ST_TX_COMPLETE = 2; // Transmission ended.
	localparam int SSF_ST_RX_MPB      = 1; // Received multiprocessor bit.
	localparam int SSF_ST_TX_MPB      = 0; // Multiprocessor bit to send.
	localparam logic [7:0] SSF_STATUS_RST  = 8'h84; // Value after reset and in standby.
	localparam logic [7:0] SSF_CONTROL_RST = 8'h00; // Everything off after reset.
	localparam logic [7:0] SSF_TXDATA_RST  = 8'hff; // Idle line pattern.

	// ==========================================================
	// Control register field positions
	// ==========================================================
	localparam int SSF_CT_RX_ENABLE = 0; // Receive enable.
	localparam int SSF_CT_TX_ENABLE = 1; // Transmit enable.
	localparam int SSF_CT_SYNC      = 2; // Synchronous mode when set.
	localparam int SSF_CT_MULTIPROC = 3; // Multiprocessor format.
	localparam int SSF_CT_PAR_EN    = 4; // Parity enable.
	localparam int SSF_CT_PAR_ODD   = 5; // Odd parity when set.
	localparam int SSF_CT_TWO_STOP  = 6; // Two stop bits.
	localparam int SSF_CT_STANDBY   = 7; // Standby: flags held at reset value.

	// ==========================================================
	// Carriers
	// ==========================================================
	// One character handed over by the receive shift datapath.
	typedef struct packed {
		logic [7:0] data;   // Data bits.
		logic       parity; // Sampled parity bit.
		logic       stop;   // Sampled first stop bit.
		logic       rx_multiproc_bit;    // Sampled multiprocessor bit.
	} ssf_rx_char_t;

	// APB answer as held in flip-flops.
	typedef struct packed {
		logic        ready;
		logic        slverr;
		logic [31:0] rdata;
	} ssf_apb_rsp_t;

endpackage

// ===== rtl/ssf_serial_status.sv
// Status flag logic of one serial channel with its APB register slave.
`timescale 1ns/1ps

module ssf_serial_status #(
	parameter int ADDR_W = 12 // APB address width.
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  rx_char_done,
	input  wire ssf_pkg::ssf_rx_char_t rx_char,
	input  wire logic                  tx_load,
	input  wire logic                  tx_last_bit,
	input  wire logic                  dma_tx_write,
	input  wire logic [7:0]            dma_tx_data,
	input  wire logic                  dma_rx_read,
	output logic                       rx_inhibit,
	output logic                       tx_inhibit,
	output logic                       tx_data_valid,
	output logic [7:0]                 tx_data,
	output logic                       tx_mpb_out,
	output logic                       rx_full_out
);

	// ==========================================================
	// Elaboration checks
	// ==========================================================
	// The map needs four words below 16 bytes.
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must lie between 4 and 32");
	end

	// ==========================================================
	// State
	// ==========================================================
	logic [7:0]            status_ff;     // Status register.
	logic [7:0]            armed_ff;      // Flags seen as one by software.
	logic [7:0]            control_ff;    // Control register.
	logic [7:0]            rx_data_reg_ff; // Receive data register.
	logic [7:0]            tx_data_reg_ff; // Transmit data register.
	logic                  tx_enable_d_ff; // Last transmit enable, for its fall.
	logic                  rx_inhibit_ff;  // Registered receive block.
	logic                  tx_inhibit_ff;  // Registered transmit block.
	logic                  tx_mpb_out_ff;  // Multiprocessor bit for the shifter.
	logic                  tx_valid_ff;    // Registered inverse of the empty flag.
	ssf_pkg::ssf_apb_rsp_t rsp_ff;         // Held APB answer.

	// ==========================================================
	// APB decode
	// ==========================================================
	// Narrows a bus address to the twelve bits the map uses.
	function automatic logic [11:0] ofs12(input logic [ADDR_W-1:0] a);
		logic [31:0] w;
		w = 32'(a);
		return w[11:0];
	endfunction

	wire logic [11:0] ofs       = ofs12(paddr);
	wire logic        hit_st    = (ofs == ssf_pkg::SSF_OFS_STATUS);
	wire logic        hit_ct    = (ofs == ssf_pkg::SSF_OFS_CONTROL);
	wire logic        hit_rxd   = (ofs == ssf_pkg::SSF_OFS_RXDATA);
	wire logic        hit_txd   = (ofs == ssf_pkg::SSF_OFS_TXDATA);
	wire logic        mapped    = hit_st | hit_ct | hit_rxd | hit_txd;
	wire logic        setup     = psel & ~penable;
	// The transfer finishes on the edge that sees pready high.
	wire logic        xfer_done = psel & penable & rsp_ff.ready;
	wire logic        wr_done   = xfer_done & pwrite & mapped;
	wire logic        rd_st     = xfer_done & ~pwrite & hit_st;
	wire logic        wr_st     = wr_done & hit_st;
	wire logic        wr_ct     = wr_done & hit_ct;
	wire logic        wr_txd    = wr_done & hit_txd;

	// ==========================================================
	// Control fields
	// ==========================================================
	wire logic rx_en    = control_ff[ssf_pkg::SSF_CT_RX_ENABLE];
	wire logic tx_en    = control_ff[ssf_pkg::SSF_CT_TX_ENABLE];
	wire logic sync_m   = control_ff[ssf_pkg::SSF_CT_SYNC];
	wire logic mp_fmt   = control_ff[ssf_pkg::SSF_CT_MULTIPROC];
	wire logic par_en   = control_ff[ssf_pkg::SSF_CT_PAR_EN];
	wire logic par_odd  = control_ff[ssf_pkg::SSF_CT_PAR_ODD];
	wire logic standby  = control_ff[ssf_pkg::SSF_CT_STANDBY];
	wire logic async_mp = ~sync_m & mp_fmt;

	// ==========================================================
	// Receive side
	// ==========================================================
	// Any of the three errors stops reception until software clears it.
	wire logic err_any = status_ff[ssf_pkg::SSF_ST_OVERRUN] | status_ff[ssf_pkg::SSF_ST_FRAMING]
		| status_ff[ssf_pkg::SSF_ST_PARITY];
	// A completion counts only while receiving is enabled and not blocked.
	wire logic rx_take  = rx_char_done & rx_en & ~err_any & ~standby;
	wire logic rx_full  = status_ff[ssf_pkg::SSF_ST_RX_FULL];
	wire logic ovr_set  = rx_take & rx_full;
	// Only the first stop bit is sampled; the second never reaches here.
	wire logic fer_set  = rx_take & ~rx_full & ~sync_m & ~rx_char.stop;
	// Even parity wants an even count of ones over data and parity bit.
	wire logic per_set  = rx_take & ~rx_full & ~sync_m & par_en
		& ((^{rx_char.data, rx_char.parity}) != par_odd);
	wire logic rx_store = rx_take & ~rx_full;
	wire logic rdf_set  = rx_store & ~fer_set & ~per_set;
	wire logic mpb_cap  = rx_store & async_mp;

	// ==========================================================
	// Transmit side
	// ==========================================================
	wire logic tx_en_fall = tx_enable_d_ff & ~tx_en;
	wire logic tde_set    = tx_load | tx_en_fall;
	wire logic tx_complete_flag_set   = (tx_last_bit & status_ff[ssf_pkg::SSF_ST_TX_EMPTY]) | tx_en_fall;

	// ==========================================================
	// Software clearing: write zero to a flag earlier read as one
	// ==========================================================
	wire logic [7:0] sw_clr = {8{wr_st}} & ~pwdata[7:0] & armed_ff;
	wire logic tde_clr  = sw_clr[ssf_pkg::SSF_ST_TX_EMPTY] | dma_tx_write;
	wire logic rdf_clr  = sw_clr[ssf_pkg::SSF_ST_RX_FULL] | dma_rx_read;
	// Clearing the empty flag by either path also ends the idle state.
	wire logic tx_complete_flag_clr = tde_clr;

	// ==========================================================
	// Next status value; a set wins over a clear in the same cycle
	// ==========================================================
	logic [7:0] nxt_status;
	always_comb begin
		nxt_status = status_ff;
		if (tde_set) begin
			nxt_status[ssf_pkg::SSF_ST_TX_EMPTY] = 1'b1;
		end else if (tde_clr) begin
			nxt_status[ssf_pkg::SSF_ST_TX_EMPTY] = 1'b0;
		end
		if (rdf_set) begin
			nxt_status[ssf_pkg::SSF_ST_RX_FULL] = 1'b1;
		end else if (rdf_clr) begin
			nxt_status[ssf_pkg::SSF_ST_RX_FULL] = 1'b0;
		end
		// Receive enable plays no part below, so the errors survive it.
		if (ovr_set) begin
			nxt_status[ssf_pkg::SSF_ST_OVERRUN] = 1'b1;
		end else if (sw_clr[ssf_pkg::SSF_ST_OVERRUN]) begin
			nxt_status[ssf_pkg::SSF_ST_OVERRUN] = 1'b0;
		end
		if (fer_set) begin
			nxt_status[ssf_pkg::SSF_ST_FRAMING] = 1'b1;
		end else if (sw_clr[ssf_pkg::SSF_ST_FRAMING]) begin
			nxt_status[ssf_pkg::SSF_ST_FRAMING] = 1'b0;
		end
		if (per_set) begin
			nxt_status[ssf_pkg::SSF_ST_PARITY] = 1'b1;
		end else if (sw_clr[ssf_pkg::SSF_ST_PARITY]) begin
			nxt_status[ssf_pkg::SSF_ST_PARITY] = 1'b0;
		end
		// Software never writes this bit directly; it follows the last bit, the transmit enable fall and the empty flag clear.
		if (tx_complete_flag_set) begin
			nxt_status[ssf_pkg::SSF_ST_TX_COMPLETE] = 1'b1;
		end else if (tx_complete_flag_clr) begin
			nxt_status[ssf_pkg::SSF_ST_TX_COMPLETE] = 1'b0;
		end
		if (mpb_cap) begin
			nxt_status[ssf_pkg::SSF_ST_RX_MPB] = rx_char.rx_multiproc_bit;
		end
		if (wr_st) begin
			nxt_status[ssf_pkg::SSF_ST_TX_MPB] = pwdata[ssf_pkg::SSF_ST_TX_MPB];
		end
		// Standby forces the reset pattern and overrides every event.
		if (standby) begin
			nxt_status = ssf_pkg::SSF_STATUS_RST;
		end
	end

	// Arming: a status read arms the writable flags that showed one.
	// A write of the status word disarms all, so each clear needs a fresh read.
	logic [7:0] nxt_armed;
	always_comb begin
		nxt_armed = armed_ff;
		if (wr_st || standby) begin
			nxt_armed = 8'h00;
		end
		if (rd_st) begin
			nxt_armed = status_ff & 8'hf8;
		end
	end

	// ==========================================================
	// Read data mux
	// ==========================================================
	wire logic [7:0] rd_byte = hit_st ? status_ff
		: hit_ct ? control_ff
		: hit_rxd ? rx_data_reg_ff
		: hit_txd ? tx_data_reg_ff : 8'h00;

	// ==========================================================
	// Flip-flops
	// ==========================================================
	// Status and arming.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_ff <= ssf_pkg::SSF_STATUS_RST;
			armed_ff  <= 8'h00;
		end else begin
			status_ff <= nxt_status;
			armed_ff  <= nxt_armed;
		end
	end

	// Control register; enable edges are tracked for the transmit end flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_ff     <= ssf_pkg::SSF_CONTROL_RST;
			tx_enable_d_ff <= 1'b0;
		end else begin
			control_ff     <= wr_ct ? pwdata[7:0] : control_ff;
			tx_enable_d_ff <= tx_en;
		end
	end

	// Data registers. On overrun the old character stays put.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data_reg_ff <= 8'h00;
			tx_data_reg_ff <= ssf_pkg::SSF_TXDATA_RST;
		end else begin
			rx_data_reg_ff <= rx_store ? rx_char.data : rx_data_reg_ff;
			tx_data_reg_ff <= dma_tx_write ? dma_tx_data : wr_txd ? pwdata[7:0] : tx_data_reg_ff;
		end
	end

	// Blocking levels and the multiprocessor bit handed to the shifter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_inhibit_ff <= 1'b0;
			tx_inhibit_ff <= 1'b0;
			tx_mpb_out_ff <= 1'b0;
			tx_valid_ff   <= 1'b0;
		end else begin
			// Follows the next status value so it still tracks the empty flag in the same cycle.
			tx_valid_ff   <= ~nxt_status[ssf_pkg::SSF_ST_TX_EMPTY];
			rx_inhibit_ff <= err_any | ~rx_en;
			tx_inhibit_ff <= sync_m & err_any;
			// Outside asynchronous multiprocessor format the bit is dropped.
			tx_mpb_out_ff <= async_mp & nxt_status[ssf_pkg::SSF_ST_TX_MPB];
		end
	end

	// APB answer: no wait state, the data is registered during setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.ready  <= setup;
			rsp_ff.slverr <= setup & ~mapped;
			rsp_ff.rdata  <= (setup & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign prdata        = rsp_ff.rdata;
	assign pready        = rsp_ff.ready;
	assign pslverr       = rsp_ff.slverr;
	assign rx_inhibit    = rx_inhibit_ff;
	assign tx_inhibit    = tx_inhibit_ff;
	assign tx_data_valid = tx_valid_ff;
	assign tx_data       = tx_data_reg_ff;
	assign tx_mpb_out    = tx_mpb_out_ff;
	assign rx_full_out   = status_ff[ssf_pkg::SSF_ST_RX_FULL];

endmodule

// ===== verif/ssf_serial_status_asserts.sv
// Port-level checks for the serial status flag block, bound into every instance.
`timescale 1ns/1ps
module ssf_serial_status_asserts #(
	parameter int ADDR_W = 12 // APB address width.
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [ADDR_W-1:0]     paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  rx_char_done,
	input wire ssf_pkg::ssf_rx_char_t rx_char,
	input wire logic                  tx_load,
	input wire logic                  tx_last_bit,
	input wire logic                  dma_tx_write,
	input wire logic [7:0]            dma_tx_data,
	input wire logic                  dma_rx_read,
	input wire logic                  rx_inhibit,
	input wire logic                  tx_inhibit,
	input wire logic                  tx_data_valid,
	input wire logic [7:0]            tx_data,
	input wire logic                  tx_mpb_out,
	input wire logic                  rx_full_out
);
	// ==========================================================
	// Helpers
	// ==========================================================
	// Any bus write in progress; it may change control or status bits.
	wire logic wr_any = psel & pwrite;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Assertions
	// ==========================================================
	// Every setup cycle is answered in the very next cycle.
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	AST_RX_FULL_CAUSE: assert property ($rose(rx_full_out) |-> $past(rx_char_done))
		else $error("receive full rose without a character");
	AST_OVERRUN_KEEP: assert property (rx_full_out && rx_char_done && !dma_rx_read && !wr_any |=> rx_full_out)
		else $error("overrun lost the full flag");
	// The inhibit sampled one cycle late reflects the state that judged the character.
	AST_RX_BLOCKED: assert property ((rx_char_done && !rx_full_out) ##1 rx_inhibit |-> !rx_full_out)
		else $error("character taken while reception blocked");
	AST_TX_INH: assert property (tx_inhibit |-> rx_inhibit)
		else $error("transmit blocked without an error");
	AST_FRAME_NO_FULL: assert property (rx_char_done && !rx_char.stop |=> !$rose(rx_full_out))
		else $error("bad stop bit set receive full");
	AST_DMA_TX: assert property (dma_tx_write && !tx_load |=> tx_data_valid && tx_data == $past(dma_tx_data))
		else $error("dma write not taken");
	// The appended bit only moves after software touches a register.
	AST_MPB_SRC: assert property ($changed(tx_mpb_out) |-> $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3))
		else $error("transmit multiprocessor bit moved by itself");

	// ==========================================================
	// Coverage
	// ==========================================================
	COV_OVERRUN: cover property (rx_full_out && rx_char_done);
	COV_TX_INH: cover property (tx_inhibit);
	COV_DMA: cover property (dma_tx_write);
endmodule

bind ssf_serial_status ssf_serial_status_asserts #(.ADDR_W(ADDR_W)) ssf_serial_status_asserts_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_char_done(rx_char_done),
	.rx_char(rx_char), .tx_load(tx_load), .tx_last_bit(tx_last_bit), .dma_tx_write(dma_tx_write),
	.dma_tx_data(dma_tx_data), .dma_rx_read(dma_rx_read), .rx_inhibit(rx_inhibit), .tx_inhibit(tx_inhibit),
	.tx_data_valid(tx_data_valid), .tx_data(tx_data), .tx_mpb_out(tx_mpb_out), .rx_full_out(rx_full_out));

// ===== verif/ssf_line_model.sv
// Model of the shifters and the DMA controller around the flag block.
`timescale 1ns/1ps
module ssf_line_model (
	input  wire logic             pclk,
	output ssf_pkg::ssf_rx_char_t rx_char,
	output logic                  rx_char_done,
	output logic                  tx_load,
	output logic                  tx_last_bit,
	output logic                  dma_tx_write,
	output logic [7:0]            dma_tx_data,
	output logic                  dma_rx_read
);
	// ==========================================================
	// Events
	// ==========================================================
	// All strobes idle at time zero.
	initial begin
		{rx_char_done, tx_load, tx_last_bit, dma_tx_write, dma_rx_read} = 5'h00;
		rx_char = 11'h000;
		dma_tx_data = 8'h00;
	end

	// One finished character; outside the pulse the bus shows junk so stale values cannot pass.
	task automatic rx(input logic [7:0] d, input logic p, input logic s, input logic m);
		rx_char_done <= 1'b1;
		rx_char <= {d, p, s, m};
		@(posedge pclk);
		rx_char_done <= 1'b0;
		rx_char <= ~{d, p, s, m};
		@(posedge pclk);
	endtask

	// One-cycle event: 0 load, 1 last bit, 2 dma write, other dma read.
	task automatic ev(input int k, input logic [7:0] d);
		case (k)
			0: tx_load <= 1'b1;
			1: tx_last_bit <= 1'b1;
			2: begin
				dma_tx_write <= 1'b1;
				dma_tx_data <= d;
			end
			default: dma_rx_read <= 1'b1;
		endcase
		@(posedge pclk);
		{tx_load, tx_last_bit, dma_tx_write, dma_rx_read} <= 4'h0;
		dma_tx_data <= ~d;
		@(posedge pclk);
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking testbench for the serial status flag block.
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Signals
	// ==========================================================
	localparam logic [11:0] ST = ssf_pkg::SSF_OFS_STATUS;  // Status.
	localparam logic [11:0] CT = ssf_pkg::SSF_OFS_CONTROL; // Control.
	localparam logic [11:0] RX = ssf_pkg::SSF_OFS_RXDATA;  // Received data.
	localparam logic [11:0] TX = ssf_pkg::SSF_OFS_TXDATA;  // Transmit data.
	// One character: control, data, parity, stop, mpb, status expected after it.
	typedef struct packed {logic [7:0] c; logic [7:0] d; logic p; logic s; logic m; logic [7:0] st;} ssf_row_t;
	logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]           paddr = 12'h000;
	logic [31:0]           pwdata = 32'h0, prdata, r;
	logic                  pready, pslverr, e, rx_char_done, tx_load, tx_last_bit, dma_tx_write, dma_rx_read;
	logic                  rx_inhibit, tx_inhibit, tx_data_valid, tx_mpb_out, rx_full_out;
	logic [7:0]            dma_tx_data, tx_data;
	ssf_pkg::ssf_rx_char_t rx_char;
	int                    mismatches = 0, checks = 0, cyc = 0;
	ssf_row_t rows [7] = '{'{8'h01, 8'h5a, 1'b0, 1'b1, 1'b0, 8'hc4}, '{8'h01, 8'h33, 1'b0, 1'b0, 1'b0, 8'h94},
		'{8'h11, 8'h01, 1'b0, 1'b1, 1'b0, 8'h8c}, '{8'h11, 8'h03, 1'b0, 1'b1, 1'b0, 8'hc4},
		'{8'h31, 8'h01, 1'b0, 1'b1, 1'b0, 8'hc4}, '{8'h31, 8'h00, 1'b0, 1'b1, 1'b0, 8'h8c},
		'{8'h09, 8'h44, 1'b0, 1'b1, 1'b1, 8'hc6}};

	always #12.5 pclk = ~pclk;

	ssf_serial_status ssf_serial_status_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_char_done(rx_char_done), .rx_char(rx_char), .tx_load(tx_load), .tx_last_bit(tx_last_bit),
		.dma_tx_write(dma_tx_write), .dma_tx_data(dma_tx_data), .dma_rx_read(dma_rx_read),
		.rx_inhibit(rx_inhibit), .tx_inhibit(tx_inhibit), .tx_data_valid(tx_data_valid), .tx_data(tx_data),
		.tx_mpb_out(tx_mpb_out), .rx_full_out(rx_full_out));
	ssf_line_model ssf_line_model_i (.pclk(pclk), .rx_char(rx_char), .rx_char_done(rx_char_done),
		.tx_load(tx_load), .tx_last_bit(tx_last_bit), .dma_tx_write(dma_tx_write),
		.dma_tx_data(dma_tx_data), .dma_rx_read(dma_rx_read));

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; an idle edge follows so back-to-back calls never drive psel twice in a step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(r, {24'h0, x});
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Sequence
	// ==========================================================
	// A hang costs at most a few thousand cycles; the whole run needs well under one thousand.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Each row: receive, check data and flags, then clear the armed flags but keep bit 7.
		foreach (rows[i]) begin
			wr(CT, rows[i].c);
			ssf_line_model_i.rx(rows[i].d, rows[i].p, rows[i].s, rows[i].m);
			rd(RX, rows[i].d);
			rd(ST, rows[i].st);
			wr(ST, 8'h80);
		end
		$display("test rows done");
		wr(CT, 8'h08);
		rd(ST, 8'h86);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ST, 8'h84);
		rd(CT, 8'h00);
		rd(TX, 8'hff);
		apb(1'b0, 12'h010, 8'h00);
		chk({31'h0, e}, 32'h1);
		$display("test reset done");
		// Overrun in synchronous mode, a third character dropped, then a DMA read.
		wr(CT, 8'h05);
		ssf_line_model_i.rx(8'h11, 1'b0, 1'b1, 1'b0);
		ssf_line_model_i.rx(8'h22, 1'b0, 1'b1, 1'b0);
		ssf_line_model_i.rx(8'h33, 1'b0, 1'b1, 1'b0);
		rd(RX, 8'h11);
		chk({31'h0, tx_inhibit}, 32'h1);
		ssf_line_model_i.ev(3, 8'h00);
		wr(CT, 8'h04);
		rd(ST, 8'ha4);
		wr(ST, 8'h1c);
		rd(ST, 8'h00);
		chk({31'h0, tx_data_valid}, 32'h1);
		$display("test overrun done");
		ssf_line_model_i.ev(0, 8'h00);
		ssf_line_model_i.ev(1, 8'h00);
		wr(ST, 8'h00);
		rd(ST, 8'h84);
		wr(ST, 8'h00);
		rd(ST, 8'h00);
		ssf_line_model_i.ev(0, 8'h00);
		ssf_line_model_i.ev(1, 8'h00);
		ssf_line_model_i.ev(2, 8'ha5);
		rd(ST, 8'h00);
		rd(TX, 8'ha5);
		wr(CT, 8'h02);
		wr(CT, 8'h00);
		rd(ST, 8'h84);
		$display("test transmit done");
		wr(CT, 8'h08);
		wr(ST, 8'h85);
		rd(ST, 8'h85);
		chk({31'h0, tx_mpb_out}, 32'h1);
		wr(CT, 8'h0c);
		rd(ST, 8'h85);
		chk({31'h0, tx_mpb_out}, 32'h0);
		$display("test multiprocessor done");
		wr(CT, 8'h01);
		ssf_line_model_i.rx(8'h77, 1'b0, 1'b0, 1'b0);
		ssf_line_model_i.rx(8'h88, 1'b0, 1'b1, 1'b0);
		rd(RX, 8'h77);
		rd(ST, 8'h95);
		wr(CT, 8'h81);
		rd(ST, 8'h84);
		$display("test standby done");
		conclude();
	end
endmodule
